// >>> gia_aggregator.sv
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps

// Operation
// [RL1] group hi bits 0-7 latch pins 100-107
// [RL2] group hi bits 8-15 latch pins 110-117
// [RL3] group hi bits 16-23 latch pins 120-127
// [RL4] group hi bits 24-30 latch pins 130-136
// [RL5] group lo bits 0-7 latch pins 040-047
// [RL6] group lo bits 8-15 latch pins 050-057
// [RL7] group lo bits 16-23 latch pins 060-067
// [RL8] per-pin level or edge detection select
// [RL9] group lo bits 24-30 reserved, zero
// [RL10] sources sticky, write one clears
// [RL11] enable set and clear by ones
// [RL12] result is source and enable, ORed
// [RL13] result bit 31 one, others reserved
module gia_aggregator
    import gia_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic [7:0]          pin_hi_bank10_i,
    input  wire logic [7:0]          pin_hi_bank11_i,
    input  wire logic [7:0]          pin_hi_bank12_i,
    input  wire logic [6:0]          pin_hi_bank13_i,
    input  wire logic [7:0]          pin_lo_bank04_i,
    input  wire logic [7:0]          pin_lo_bank05_i,
    input  wire logic [7:0]          pin_lo_bank06_i,
    input  wire logic                hsel_i,
    input  wire logic [31:0]         haddr_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hwrite_i,
    input  wire logic [2:0]          hsize_i,
    input  wire logic [31:0]         hwdata_i,
    input  wire logic                hready_i,
    output logic      [31:0]         hrdata_o,
    output logic                     hreadyout_o,
    output logic                     hresp_o,
    output logic                     pin_group_hi_aggregator_o,
    output logic                     pin_group_lo_aggregator_o,
    output logic      [30:0]         wake_hi_o,
    output logic      [30:0]         wake_lo_o
);

    // ==========================================================
    // pin mapping into group source positions
    logic [GIA_PINS-1:0] pins;
    logic [30:0]         map_hi;
    logic [30:0]         map_lo;

    assign map_hi[7:0]   = pin_hi_bank10_i; // RL1
    assign map_hi[15:8]  = pin_hi_bank11_i; // RL2
    assign map_hi[23:16] = pin_hi_bank12_i; // RL3
    assign map_hi[30:24] = pin_hi_bank13_i; // RL4
    assign map_lo[7:0]   = pin_lo_bank04_i; // RL5
    assign map_lo[15:8]  = pin_lo_bank05_i; // RL6
    assign map_lo[23:16] = pin_lo_bank06_i; // RL7
    assign map_lo[30:24] = 7'h00;           // RL9
    assign pins = {map_lo[GIA_LO_PINS-1:0], map_hi};

    // ==========================================================
    // event detection
    // detect types live in one word per sixteen pins
    logic [1:0]          det_ff  [GIA_PINS];
    logic [1:0]          nxt_det [GIA_PINS];
    logic [GIA_PINS-1:0] prev_ff;
    logic [GIA_PINS-1:0] nxt_prev;
    logic [GIA_PINS-1:0] evt;

    genvar g;
    generate
        for (g = 0; g < GIA_PINS; g++) begin : g_det
            always_comb begin
                unique case (gia_det_type'(det_ff[g]))
                    GIA_DET_LOW:  evt[g] = ~pins[g]; // RL8
                    GIA_DET_HIGH: evt[g] = pins[g]; // RL8
                    GIA_DET_RISE: evt[g] = pins[g] & ~prev_ff[g]; // RL8
                    GIA_DET_FALL: evt[g] = ~pins[g] & prev_ff[g]; // RL8
                endcase
            end
        end
    endgenerate

    // ==========================================================
    // ahb-lite slave, zero wait states
    gia_aphase_type ap_ff;
    gia_aphase_type nxt_ap;
    logic [31:0]    rdata_ff;
    logic [31:0]    nxt_rdata;

    always_comb begin
        nxt_ap.valid = hsel_i & hready_i & htrans_i[1];
        nxt_ap.write = hwrite_i;
        nxt_ap.addr  = haddr_i[7:0];
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = rdata_ff;

    // ==========================================================
    // source, enable and detect state
    logic [30:0] src_hi_ff;
    logic [30:0] src_lo_ff;
    logic [30:0] en_hi_ff;
    logic [30:0] en_lo_ff;
    logic [30:0] nxt_src_hi;
    logic [30:0] nxt_src_lo;
    logic [30:0] nxt_en_hi;
    logic [30:0] nxt_en_lo;
    logic [30:0] evt_hi;
    logic [30:0] evt_lo;
    logic [30:0] wd;
    logic        wr;

    assign evt_hi = evt[GIA_HI_PINS-1:0];
    assign evt_lo = {7'h00, evt[GIA_PINS-1:GIA_HI_PINS]};
    assign wd     = hwdata_i[30:0];
    assign wr     = ap_ff.valid & ap_ff.write;

    // ==========================================================
    // write strobes, one per source and enable register word
    logic wr_hi_src;
    logic wr_hi_ens;
    logic wr_hi_enc;
    logic wr_lo_src;
    logic wr_lo_ens;
    logic wr_lo_enc;

    assign wr_hi_src = wr && (ap_ff.addr == GIA_HI_SRC_OFS);
    assign wr_hi_ens = wr && (ap_ff.addr == GIA_HI_ENS_OFS);
    assign wr_hi_enc = wr && (ap_ff.addr == GIA_HI_ENC_OFS);
    assign wr_lo_src = wr && (ap_ff.addr == GIA_LO_SRC_OFS);
    assign wr_lo_ens = wr && (ap_ff.addr == GIA_LO_ENS_OFS);
    assign wr_lo_enc = wr && (ap_ff.addr == GIA_LO_ENC_OFS);
    // result words have no strobe: writes there are dropped

    // ==========================================================
    // sticky sources
    always_comb begin
        nxt_src_hi = src_hi_ff;
        nxt_src_lo = src_lo_ff;
        if (wr_hi_src) begin
            nxt_src_hi = src_hi_ff & ~wd; // RL10
        end
        if (wr_lo_src) begin
            nxt_src_lo = src_lo_ff & ~wd; // RL10
        end
        // set wins over clear, independent of enable
        nxt_src_hi = (nxt_src_hi | evt_hi) & GIA_HI_VALID; // RL10
        nxt_src_lo = (nxt_src_lo | evt_lo) & GIA_LO_VALID; // RL9
    end

    // ==========================================================
    // enables, set and clear by ones
    always_comb begin
        nxt_en_hi = en_hi_ff;
        nxt_en_lo = en_lo_ff;
        if (wr_hi_ens) begin
            nxt_en_hi = en_hi_ff | wd; // RL11
        end
        if (wr_hi_enc) begin
            nxt_en_hi = en_hi_ff & ~wd; // RL11
        end
        if (wr_lo_ens) begin
            nxt_en_lo = en_lo_ff | wd; // RL11
        end
        if (wr_lo_enc) begin
            nxt_en_lo = en_lo_ff & ~wd; // RL11
        end
        nxt_en_hi = nxt_en_hi & GIA_HI_VALID;
        nxt_en_lo = nxt_en_lo & GIA_LO_VALID; // RL9
    end

    // detect words: word k holds pins 16k..16k+15, two bits each
    localparam int GIA_DET_USED = (GIA_PINS + GIA_DET_PER_WD - 1) / GIA_DET_PER_WD;
    logic [GIA_DET_USED-1:0] wr_det;
    genvar w;
    generate
        for (w = 0; w < GIA_DET_USED; w++) begin : g_detsel
            assign wr_det[w] = wr && (ap_ff.addr == GIA_DET_OFS + 8'(w * 4));
        end
    endgenerate

    generate
        for (g = 0; g < GIA_PINS; g++) begin : g_detw
            always_comb begin
                nxt_det[g] = det_ff[g];
                if (wr_det[g / GIA_DET_PER_WD]) begin
                    nxt_det[g] = hwdata_i[(g % GIA_DET_PER_WD)*2 +: 2]; // RL8
                end
            end
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    det_ff[g] <= GIA_DET_RST;
                end else begin
                    det_ff[g] <= nxt_det[g];
                end
            end
        end
    endgenerate

    // ==========================================================
    // results and group vectors
    logic [30:0] res_hi;
    logic [30:0] res_lo;

    assign res_hi = src_hi_ff & en_hi_ff; // RL12
    assign res_lo = src_lo_ff & en_lo_ff; // RL12
    assign pin_group_hi_aggregator_o = |res_hi; // RL12
    assign pin_group_lo_aggregator_o = |res_lo; // RL12
    // wake follows the raw source so a stopped clock tree can restart
    assign wake_hi_o = src_hi_ff & GIA_HI_VALID;
    assign wake_lo_o = src_lo_ff & GIA_LO_VALID; // RL9

    // ==========================================================
    // read mux, captured at the end of the address phase
    logic [31:0] det_rd;
    int          k;

    always_comb begin
        det_rd = 32'h00000000;
        for (k = 0; k < GIA_PINS; k++) begin
            if (haddr_i[7:0] == GIA_DET_OFS + 8'((k / GIA_DET_PER_WD) * 4)) begin
                det_rd[(k % GIA_DET_PER_WD)*2 +: 2] = det_ff[k];
            end
        end
    end

    always_comb begin
        nxt_rdata = 32'h00000000;
        if (nxt_ap.valid && !hwrite_i) begin
            unique case (haddr_i[7:0])
                GIA_HI_SRC_OFS: nxt_rdata = {1'b0, src_hi_ff}; // RL13
                GIA_HI_ENS_OFS,
                GIA_HI_ENC_OFS: nxt_rdata = {1'b0, en_hi_ff}; // RL11
                GIA_HI_RES_OFS: nxt_rdata = {1'b1, res_hi}; // RL13
                GIA_LO_SRC_OFS: nxt_rdata = {1'b0, src_lo_ff};
                GIA_LO_ENS_OFS,
                GIA_LO_ENC_OFS: nxt_rdata = {1'b0, en_lo_ff};
                GIA_LO_RES_OFS: nxt_rdata = {1'b1, res_lo}; // RL13
                default:        nxt_rdata = det_rd;
            endcase
        end
    end

    // ==========================================================
    // bus capture registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ap_ff <= '0;
        end else begin
            ap_ff <= nxt_ap;
        end
    end

    // read data stands for the data phase only
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================
    // source registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            src_hi_ff <= GIA_SRC_RST;
            src_lo_ff <= GIA_SRC_RST;
        end else begin
            src_hi_ff <= nxt_src_hi;
            src_lo_ff <= nxt_src_lo;
        end
    end

    // ==========================================================
    // enable registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_hi_ff <= GIA_EN_RST;
            en_lo_ff <= GIA_EN_RST;
        end else begin
            en_hi_ff <= nxt_en_hi;
            en_lo_ff <= nxt_en_lo;
        end
    end

    // ==========================================================
    // previous pin level for edge detection
    // tracks the pins one cycle after reset, before any edge type is set
    always_comb begin
        nxt_prev = pins;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= nxt_prev;
        end
    end

endmodule

// >>> gia_aggregator_bench.sv
`timescale 1ns/1ps
module gia_aggregator_bench import gia_pkg::*;;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [54:0] lvl = '1;
    logic [31:0] hrdata, q, e;
    logic [7:0]  a;
    logic        hrdy, vhi, vlo;
    logic        hresp;
    logic [30:0] whi, wlo;
    logic [6:0]  b13;
    logic [7:0]  b10, b11, b12, b04, b05, b06;
    int          fail_count = 0;
    int          n_compared = 0;
    int          i;
    initial forever #50 clk_i = ~clk_i;
    gia_pin_model u_gia_pin_model (.clk_i(clk_i), .lvl_i(lvl), .b10_o(b10), .b11_o(b11),
        .b12_o(b12), .b13_o(b13), .b04_o(b04), .b05_o(b05), .b06_o(b06));
    gia_aggregator u_gia_aggregator (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pin_hi_bank10_i(b10),
        .pin_hi_bank11_i(b11), .pin_hi_bank12_i(b12), .pin_hi_bank13_i(b13),
        .pin_lo_bank04_i(b04), .pin_lo_bank05_i(b05), .pin_lo_bank06_i(b06), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .pin_group_hi_aggregator_o(vhi), .pin_group_lo_aggregator_o(vlo), .wake_hi_o(whi),
        .wake_lo_o(wlo));
    // ==========================================================
    // tasks
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d compared %0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ready and read data taken at the rising edge, before that edge's updates land
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk_i);
        while (hrdy !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 20) begin
            fail_count++;
            finish_test();
        end
        q = hrdata;
        check("response", {31'h0, hresp}, 32'h0);
    endtask
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= {24'h0, ad};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [31:0] x);
        xfer(1'b0, ad, 32'h0);
        check("register", q, x);
    endtask
    task automatic pulse(input int k, input logic v);
        lvl[k] <= v;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic vchk(input logic [1:0] x);
        @(negedge clk_i);
        check("vectors", {30'h0, vlo, vhi}, {30'h0, x});
        @(posedge clk_i);
    endtask
    // ==========================================================
    // sequence
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 55; i++) begin
            pulse(i, 1'b0);
            pulse(i, 1'b1);
            a = (i < 31) ? GIA_HI_SRC_OFS : GIA_LO_SRC_OFS;
            e = (i < 31) ? (32'h1 << i) : (32'h1 << (i - 31));
            rchk(a, e);
            @(negedge clk_i);
            q = (i < 31) ? {1'b0, whi} : {1'b0, wlo};
            check("wake", q, e);
            @(posedge clk_i);
            xfer(1'b1, a, 32'h0);
            rchk(a, e);
            xfer(1'b1, a, e);
            rchk(a, 32'h0);
        end
        xfer(1'b1, GIA_HI_ENS_OFS, 32'h5);
        rchk(GIA_HI_ENS_OFS, 32'h5);
        xfer(1'b1, GIA_HI_ENC_OFS, 32'h1);
        xfer(1'b1, GIA_HI_ENC_OFS, 32'h0);
        rchk(GIA_HI_ENC_OFS, 32'h4);
        pulse(0, 1'b0);
        pulse(0, 1'b1);
        rchk(GIA_HI_RES_OFS, 32'h8000_0000);
        vchk(2'h0);
        pulse(2, 1'b0);
        pulse(2, 1'b1);
        rchk(GIA_HI_SRC_OFS, 32'h5);
        rchk(GIA_HI_RES_OFS, 32'h8000_0004);
        vchk(2'h1);
        xfer(1'b1, GIA_HI_SRC_OFS, 32'h5);
        vchk(2'h0);
        xfer(1'b1, GIA_LO_ENS_OFS, 32'hFFFF_FFFF);
        rchk(GIA_LO_ENC_OFS, 32'h00FF_FFFF);
        pulse(31, 1'b0);
        pulse(31, 1'b1);
        vchk(2'h2);
        rchk(GIA_LO_RES_OFS, 32'h8000_0001);
        xfer(1'b1, GIA_LO_SRC_OFS, 32'h1);
        vchk(2'h0);
        rchk(8'h60, 32'h0);
        // pin 0 through high, rise and fall detection
        xfer(1'b1, GIA_DET_OFS, 32'h1);
        xfer(1'b1, GIA_HI_SRC_OFS, 32'h1);
        rchk(GIA_HI_SRC_OFS, 32'h1);
        pulse(0, 1'b0);
        xfer(1'b1, GIA_HI_SRC_OFS, 32'h1);
        rchk(GIA_HI_SRC_OFS, 32'h0);
        xfer(1'b1, GIA_DET_OFS, 32'h2);
        pulse(0, 1'b1);
        rchk(GIA_HI_SRC_OFS, 32'h1);
        xfer(1'b1, GIA_DET_OFS, 32'h3);
        xfer(1'b1, GIA_HI_SRC_OFS, 32'h1);
        rchk(GIA_HI_SRC_OFS, 32'h0);
        pulse(0, 1'b0);
        rchk(GIA_HI_SRC_OFS, 32'h1);
        finish_test();
    end
endmodule

// >>> gia_aggregator_sva.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module gia_aggregator_sva
    import gia_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        pin_group_hi_aggregator_o,
    input wire logic        pin_group_lo_aggregator_o,
    input wire logic [30:0] wake_hi_o,
    input wire logic [30:0] wake_lo_o
);
    logic       take;
    logic       wr_ff;
    logic       rd_ff;
    logic [7:0] ofs_ff;
    assign take = hsel_i && hready_i && htrans_i[1];
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ff  <= 1'b0;
            rd_ff  <= 1'b0;
            ofs_ff <= 8'h00;
        end else begin
            wr_ff  <= take && hwrite_i;
            rd_ff  <= take && !hwrite_i;
            ofs_ff <= haddr_i[7:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    hi_vector_a: assert property (pin_group_hi_aggregator_o |-> |wake_hi_o)
        else $error("hi vector without source");
    lo_vector_a: assert property (pin_group_lo_aggregator_o |-> |wake_lo_o)
        else $error("lo vector without source");
    lo_wake_resv_a: assert property (wake_lo_o[30:24] == 7'h00)
        else $error("lo reserved source set");
    lo_read_resv_a: assert property (rd_ff && ofs_ff[7:4] == 4'h1 |-> hrdata_o[30:24] == 7'h00)
        else $error("lo reserved bits read nonzero");
    // sources only drop after a write to their own word
    hi_sticky_a: assert property (!(wr_ff && ofs_ff == GIA_HI_SRC_OFS)
        |=> (wake_hi_o & $past(wake_hi_o)) == $past(wake_hi_o)) else $error("hi source lost");
    lo_sticky_a: assert property (!(wr_ff && ofs_ff == GIA_LO_SRC_OFS)
        |=> (wake_lo_o & $past(wake_lo_o)) == $past(wake_lo_o)) else $error("lo source lost");
    result_top_a: assert property (rd_ff && ofs_ff inside {8'h08, 8'h18} |-> hrdata_o[31])
        else $error("result bit 31 not one");
    other_top_a: assert property (rd_ff && ofs_ff inside {8'h00, 8'h04, 8'h0C, 8'h10,
        8'h14, 8'h1C} |-> !hrdata_o[31]) else $error("reserved bit 31 set");
endmodule

bind gia_aggregator gia_aggregator_sva u_gia_aggregator_sva (.clk_i, .sys_rst_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .pin_group_hi_aggregator_o,
    .pin_group_lo_aggregator_o, .wake_hi_o, .wake_lo_o);

// >>> gia_pin_model.sv
`timescale 1ns/1ps
// ==========================================================
// pin levels, registered like synchronised pins
module gia_pin_model (
    input  wire logic        clk_i,
    input  wire logic [54:0] lvl_i,
    output logic      [7:0]  b10_o,
    output logic      [7:0]  b11_o,
    output logic      [7:0]  b12_o,
    output logic      [6:0]  b13_o,
    output logic      [7:0]  b04_o,
    output logic      [7:0]  b05_o,
    output logic      [7:0]  b06_o
);
    // idle high so the default low-level detection stays quiet
    logic [54:0] lvl_ff = '1;
    always_ff @(posedge clk_i) lvl_ff <= lvl_i;
    assign b10_o = lvl_ff[7:0];
    assign b11_o = lvl_ff[15:8];
    assign b12_o = lvl_ff[23:16];
    assign b13_o = lvl_ff[30:24];
    assign b04_o = lvl_ff[38:31];
    assign b05_o = lvl_ff[46:39];
    assign b06_o = lvl_ff[54:47];
endmodule

// >>> gia_pkg.sv
package gia_pkg;

    // ==========================================================
    // register map, one aligned word each
    localparam logic [7:0] GIA_HI_SRC_OFS = 8'h00;
    localparam logic [7:0] GIA_HI_ENS_OFS = 8'h04;
    localparam logic [7:0] GIA_HI_RES_OFS = 8'h08;
    localparam logic [7:0] GIA_HI_ENC_OFS = 8'h0C;
    localparam logic [7:0] GIA_LO_SRC_OFS = 8'h10;
    localparam logic [7:0] GIA_LO_ENS_OFS = 8'h14;
    localparam logic [7:0] GIA_LO_RES_OFS = 8'h18;
    localparam logic [7:0] GIA_LO_ENC_OFS = 8'h1C;
    localparam logic [7:0] GIA_DET_OFS    = 8'h20;
    localparam int         GIA_DET_WORDS  = 16;

    // ==========================================================
    // field layout and reset values
    localparam int          GIA_SRC_BITS   = 31;
    localparam int          GIA_HI_PINS    = 31;
    localparam int          GIA_LO_PINS    = 24;
    localparam int          GIA_PINS       = GIA_HI_PINS + GIA_LO_PINS;
    localparam int          GIA_DET_PER_WD = 16;
    localparam logic [30:0] GIA_HI_VALID   = 31'h7FFFFFFF;
    localparam logic [30:0] GIA_LO_VALID   = 31'h00FFFFFF;
    localparam logic [30:0] GIA_SRC_RST    = 31'h00000000;
    localparam logic [30:0] GIA_EN_RST     = 31'h00000000;
    localparam logic [1:0]  GIA_DET_RST    = 2'h0;

    // ==========================================================
    // detection types
    typedef enum logic [1:0] {
        GIA_DET_LOW  = 2'b00,
        GIA_DET_HIGH = 2'b01,
        GIA_DET_RISE = 2'b10,
        GIA_DET_FALL = 2'b11
    } gia_det_type;

    // ==========================================================
    // ahb address phase captured for the data phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } gia_aphase_type;

endpackage
